// ---- scb_pkg.sv ----
package scb_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // word layout
  localparam int WORD_W = 16;
  localparam int DATA_W = 14;
  localparam int ADDR_W = 2;
  localparam int CNT_W = 5;

  // address field codes
  localparam logic [1:0] ADDR_PLL = 2'h0;
  localparam logic [1:0] ADDR_CHAN = 2'h1;
  localparam logic [1:0] ADDR_TEST = 2'h2;
  localparam logic [1:0] ADDR_NONE = 2'h3;

  // reset values
  localparam logic [13:0] PLL_RST = 14'h0000;
  localparam logic [13:0] CHAN_RST = 14'h0000;
  localparam logic [13:0] TEST_RST = 14'h0000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic RX_ON_RST = 1'b0;

  // field positions inside the data field
  localparam int TPC_BIT = 5;
  localparam int TX_LOOP_CLOSED_BIT = 4;
  localparam int LOL_BIT = 3;
  localparam int RX_LOOP_CLOSED_BIT = 2;
  localparam int RD_BIT = 1;
  localparam int QPP_BIT = 0;
  localparam int CHQ_LSB = 0;
  localparam int CHQ_W = 12;
  localparam int DPROBE_LSB = 3;
  localparam int APROBE_LSB = 0;
  localparam int PROBE_W = 3;

  // reference divide ratios
  localparam logic [3:0] REF_DIV_LOW = 4'h6;
  localparam logic [3:0] REF_DIV_HIGH = 4'hC;

  // digital probe codes
  localparam logic [2:0] DPROBE_DEMOD = 3'h0;
  localparam logic [2:0] DPROBE_AGC = 3'h1;
  localparam logic [2:0] DPROBE_MAIN_DIV = 3'h2;
  localparam logic [2:0] DPROBE_REF_DIV = 3'h3;

  //////////////////////////////////////////////////////////////////////////////
  // register images
  typedef struct packed {
    logic [7:0] rsvd;
    logic tx_power_pin_ctrl;
    logic tx_loop_closed;
    logic lo_offset_swap;
    logic rx_loop_closed;
    logic ref_divide_sel;
    logic pump_polarity;
  } scb_pll_cfg_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [11:0] channel_divide_ratio_field;
  } scb_chan_t;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [2:0] digital_probe_sel;
    logic [2:0] analog_probe_sel;
  } scb_test_t;

  typedef struct packed {
    logic [13:0] data;
    logic addr_hi;
    logic addr_lo;
  } scb_word_t;

  // test signal sources for the receive data output
  typedef struct packed {
    logic demod_data;
    logic agc_state;
    logic main_div_out;
    logic ref_div_out;
  } scb_probe_src_t;

endpackage

// ---- scb_sync2.sv ----
`timescale 1ns/1ps

// two flop synchroniser; first stage feeds only the second
module scb_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // async input
  input wire logic [WIDTH-1:0] async_in,
  // synchronised output
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // scb_sync2

// ---- scb_serial_config_bank.sv ----
`timescale 1ns/1ps

// Function
// [R1] each word is sixteen bits: fourteen data bits then two address bits
// [R2] data shifted msb first from data bit 13, then upper address bit first
// [R3] load writes last sixteen shifted bits to addressed register, older bits dropped
// [R4] controller always shifts full sixteen bits before load; shorter is undefined
// [R5] address 00 pll, 01 channel, 10 test, 11 selects nothing
// [R6] all configuration registers clear to zero at power up
// [R7] controller loads pll and channel registers before first transceiver enable
// [R8] controller writes reserved data bits as zero
// [R9] pll bit 5 drives open drain power pin: 0 released, 1 pulled low
// [R10] pll bit 4: 0 fsk transmit, 1 unmodulated cw test transmit
// [R11] pll bit 3 swaps lo offset between receive and transmit
// [R12] pll bit 2: 0 receive loop open, 1 receive loop closed
// [R13] pll bit 1 selects reference divide for 6.144 or 12.288 mhz reference
// [R14] pll bit 0: 0 pump sources when signal below reference, 1 sinks
// [R15] channel bits 11..0 hold main divide ratio, channel mhz over 0.512
// [R16] test bits 5..3 form digital probe select, msb at bit 5
// [R17] test bits 2..0 form analog probe select, msb at bit 2
// [R18] serial bus is receive only; no readback, data line never driven
// [R19] strobe low: shift data on rising serial clock; strobe rise latches word
// [R20] strobe high: data and serial clock activity is ignored
// [R21] power pin takes new value only at falling edge of receive on
// [R22] nonzero digital probe routes agc, main or reference divider to rx data; codes 4 to 7 route demod data instead
// [R23] registers change only at load; shifting never disturbs applied values
module scb_serial_config_bank (
  // system clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial link
  input wire logic sclk,
  input wire logic ld_strobe,
  input wire logic sdata,
  // parallel control
  input wire logic receive_on,
  // test signal sources, same clock
  input wire scb_pkg::scb_probe_src_t probe_src,
  // open drain power control pin
  output logic tx_power_pin_o,
  output logic tx_power_pin_oe,
  // pll controls
  output logic tx_cw_mode,
  output logic tx_lo_offset_en,
  output logic rx_lo_offset_en,
  output logic rx_loop_closed,
  output logic [3:0] ref_divide_ratio,
  output logic pump_sink,
  // channel and test controls
  output logic [11:0] main_divide_ratio,
  output logic [2:0] digital_probe_sel,
  output logic [2:0] analog_probe_sel,
  // receive data output
  output logic rx_data_out,
  // load event seen, one cycle
  output logic load_pulse
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // one hot select of the addressed register; code 11 selects none
  function automatic logic [2:0] addr_sel(input logic [1:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    unique case (addr)
      scb_pkg::ADDR_PLL: sel = 3'h1; // see [R5]
      scb_pkg::ADDR_CHAN: sel = 3'h2; // see [R5]
      scb_pkg::ADDR_TEST: sel = 3'h4; // see [R5]
      scb_pkg::ADDR_NONE: sel = 3'h0; // see [R5]
    endcase
    return sel;
  endfunction

  // reference divide ratio from the select bit
  function automatic logic [3:0] ref_ratio(input logic sel);
    return sel ? scb_pkg::REF_DIV_HIGH : scb_pkg::REF_DIV_LOW;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // link domain: shift register on the serial clock

  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;

  // newest bit enters at the bottom, so after sixteen clocks the first bit
  // (data bit 13) sits at the top and the lower address bit at the bottom
  always_comb
  begin
    nxt_shift = {shift_ff[14:0], sdata}; // see [R2]
  end

  // strobe high freezes the word, which is what makes the crossing safe:
  // the system side copies it only while it cannot move
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_ff <= scb_pkg::SHIFT_RST;
    end
    else if (!ld_strobe) // see [R19] [R20]
    begin
      shift_ff <= nxt_shift; // see [R1] [R3]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock

  logic strobe_sync;
  logic rx_on_sync;

  // the strobe idles high, so its flops reset high: a low reset value would
  // look like a strobe rise two clocks after reset and load a stale word
  scb_sync2 #(
    .WIDTH(1),
    .RST_VAL(scb_pkg::STROBE_IDLE)
  ) u_sync_strobe (
    .clk(clk),
    .rstn(rstn),
    .async_in(ld_strobe),
    .sync_out(strobe_sync)
  );

  // receive on resets low: a release while the pin is high reads as a rise,
  // never as the fall that applies the power pin
  scb_sync2 #(
    .WIDTH(1),
    .RST_VAL(scb_pkg::RX_ON_RST)
  ) u_sync_rx_on (
    .clk(clk),
    .rstn(rstn),
    .async_in(receive_on),
    .sync_out(rx_on_sync)
  );

  logic strobe_d_ff;
  logic rx_on_d_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strobe_d_ff <= scb_pkg::STROBE_IDLE; // see [R19]
    end
    else
    begin
      strobe_d_ff <= strobe_sync;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_on_d_ff <= scb_pkg::RX_ON_RST;
    end
    else
    begin
      rx_on_d_ff <= rx_on_sync;
    end
  end

  logic strobe_rise;
  logic rx_on_fall;

  assign strobe_rise = strobe_sync & ~strobe_d_ff; // see [R19]
  assign rx_on_fall = rx_on_d_ff & ~rx_on_sync; // see [R21]

  //////////////////////////////////////////////////////////////////////////////
  // load decode

  scb_pkg::scb_word_t word;
  logic [2:0] sel;

  // the word is static here: the strobe has been high for two clocks
  assign word = scb_pkg::scb_word_t'(shift_ff); // see [R3]
  assign sel = addr_sel({word.addr_hi, word.addr_lo}); // see [R5]

  logic load_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      load_ff <= 1'b0;
    end
    else
    begin
      load_ff <= strobe_rise;
    end
  end

  assign load_pulse = load_ff;

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers; written only on a load event

  scb_pkg::scb_pll_cfg_t pll_configuration_ff;
  scb_pkg::scb_chan_t channel_divide_ratio_ff;
  scb_pkg::scb_test_t test_access_ff;

  // reserved bits are stored as written; the controller keeps them zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pll_configuration_ff <= scb_pkg::scb_pll_cfg_t'(scb_pkg::PLL_RST); // see [R6]
    end
    else if (strobe_rise && sel[0]) // see [R23]
    begin
      pll_configuration_ff <= scb_pkg::scb_pll_cfg_t'(word.data); // see [R3]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_divide_ratio_ff <= scb_pkg::scb_chan_t'(scb_pkg::CHAN_RST); // see [R6]
    end
    else if (strobe_rise && sel[1]) // see [R23]
    begin
      channel_divide_ratio_ff <= scb_pkg::scb_chan_t'(word.data); // see [R3]
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      test_access_ff <= scb_pkg::scb_test_t'(scb_pkg::TEST_RST); // see [R6]
    end
    else if (strobe_rise && sel[2]) // see [R23]
    begin
      test_access_ff <= scb_pkg::scb_test_t'(word.data); // see [R3]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power control pin: applied only at the end of receive

  logic tpc_applied_ff;

  // a new setting waits for the receive to transmit turnaround so the
  // external amplifier never switches mid burst
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tpc_applied_ff <= 1'b0;
    end
    else if (rx_on_fall) // see [R21]
    begin
      tpc_applied_ff <= pll_configuration_ff.tx_power_pin_ctrl;
    end
  end

  // open drain: only ever drives low
  assign tx_power_pin_o = 1'b0; // see [R9]
  assign tx_power_pin_oe = tpc_applied_ff; // see [R9]

  //////////////////////////////////////////////////////////////////////////////
  // pll controls

  assign tx_cw_mode = pll_configuration_ff.tx_loop_closed; // see [R10]
  assign tx_lo_offset_en = pll_configuration_ff.lo_offset_swap; // see [R11]
  assign rx_lo_offset_en = ~pll_configuration_ff.lo_offset_swap; // see [R11]
  assign rx_loop_closed = pll_configuration_ff.rx_loop_closed; // see [R12]
  assign pump_sink = pll_configuration_ff.pump_polarity; // see [R14]

  logic [3:0] ref_ratio_ff;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_ratio_ff <= scb_pkg::REF_DIV_LOW;
    end
    else
    begin
      ref_ratio_ff <= ref_ratio(pll_configuration_ff.ref_divide_sel); // see [R13]
    end
  end

  assign ref_divide_ratio = ref_ratio_ff;

  //////////////////////////////////////////////////////////////////////////////
  // channel and test fields

  assign main_divide_ratio = channel_divide_ratio_ff.channel_divide_ratio_field; // see [R15]
  assign digital_probe_sel = test_access_ff.digital_probe_sel; // see [R16]
  assign analog_probe_sel = test_access_ff.analog_probe_sel; // see [R17]

  //////////////////////////////////////////////////////////////////////////////
  // receive data mux

  logic nxt_rx_data;
  logic rx_data_ff;

  // undefined probe codes fall back to demodulated data
  always_comb
  begin
    nxt_rx_data = probe_src.demod_data;
    unique case (test_access_ff.digital_probe_sel)
      scb_pkg::DPROBE_AGC: nxt_rx_data = probe_src.agc_state; // see [R22]
      scb_pkg::DPROBE_MAIN_DIV: nxt_rx_data = probe_src.main_div_out; // see [R22]
      scb_pkg::DPROBE_REF_DIV: nxt_rx_data = probe_src.ref_div_out; // see [R22]
      default: nxt_rx_data = probe_src.demod_data; // see [R22]
    endcase
  end

  // one flop of latency is traded for a glitch free output
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_data_ff <= 1'b0;
    end
    else
    begin
      rx_data_ff <= nxt_rx_data;
    end
  end

  assign rx_data_out = rx_data_ff;

  // no serial output exists at all: nothing can be read back // see [R18]

endmodule // scb_serial_config_bank

// ---- scb_checker.sv ----
`timescale 1ns/1ps

module scb_checker (
  // clocks and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  // link and control inputs
  input wire logic ld_strobe,
  input wire logic sdata,
  input wire logic receive_on,
  input wire scb_pkg::scb_probe_src_t probe_src,
  // outputs
  input wire logic tx_power_pin_o,
  input wire logic tx_power_pin_oe,
  input wire logic tx_cw_mode,
  input wire logic tx_lo_offset_en,
  input wire logic rx_lo_offset_en,
  input wire logic rx_loop_closed,
  input wire logic [3:0] ref_divide_ratio,
  input wire logic pump_sink,
  input wire logic [11:0] main_divide_ratio,
  input wire logic [2:0] digital_probe_sel,
  input wire logic [2:0] analog_probe_sel,
  input wire logic rx_data_out,
  input wire logic load_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // age of the last receive_on fall, saturating so old falls never excuse a change
  logic [2:0] fall_age_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fall_age_ff <= 3'h7;
    else if ($fell(receive_on))
      fall_age_ff <= 3'h0;
    else if (fall_age_ff != 3'h7)
      fall_age_ff <= fall_age_ff + 3'h1;
  end

  function automatic logic pick(input logic [2:0] s, input scb_pkg::scb_probe_src_t p);
    case (s)
      3'h1: return p.agc_state;
      3'h2: return p.main_div_out;
      3'h3: return p.ref_div_out;
      default: return p.demod_data;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  a_pin_drive_low: assert property (tx_power_pin_o == 1'b0)
    else $error("power pin output driven high");
  a_lo_swap_pair: assert property (rx_lo_offset_en != tx_lo_offset_en)
    else $error("lo offsets not complementary");
  a_ref_ratio_code: assert property (ref_divide_ratio == scb_pkg::REF_DIV_LOW ||
    ref_divide_ratio == scb_pkg::REF_DIV_HIGH) else $error("bad reference ratio");
  a_probe_route: assert property ($past(rstn) |->
    rx_data_out == pick($past(digital_probe_sel), $past(probe_src)))
    else $error("receive data not routed from selected source");
  a_load_one_cycle: assert property (load_pulse |=> !load_pulse)
    else $error("load pulse longer than one cycle");
  a_change_at_load: assert property ($changed({tx_cw_mode, tx_lo_offset_en,
    rx_loop_closed, ref_divide_ratio, pump_sink, main_divide_ratio, digital_probe_sel,
    analog_probe_sel}) |-> load_pulse || $past(load_pulse))
    else $error("control changed without load");
  a_strobe_before_load: assert property (load_pulse |->
    ld_strobe && $past(ld_strobe, 2)) else $error("load without strobe high");
  a_pin_at_fall: assert property ($changed(tx_power_pin_oe) |->
    fall_age_ff inside {[3'h1:3'h5]}) else $error("power pin changed off receive fall");
  a_reset_defaults: assert property ($rose(rstn) |-> main_divide_ratio == 12'h000 &&
    ref_divide_ratio == scb_pkg::REF_DIV_LOW && !tx_cw_mode && !tx_power_pin_oe &&
    digital_probe_sel == 3'h0 && analog_probe_sel == 3'h0) else $error("bad reset value");
endmodule // scb_checker

bind scb_serial_config_bank scb_checker scb_checker_i (.clk(clk), .rstn(rstn),
  .sclk(sclk), .ld_strobe(ld_strobe), .sdata(sdata), .receive_on(receive_on),
  .probe_src(probe_src), .tx_power_pin_o(tx_power_pin_o),
  .tx_power_pin_oe(tx_power_pin_oe), .tx_cw_mode(tx_cw_mode),
  .tx_lo_offset_en(tx_lo_offset_en), .rx_lo_offset_en(rx_lo_offset_en),
  .rx_loop_closed(rx_loop_closed), .ref_divide_ratio(ref_divide_ratio),
  .pump_sink(pump_sink), .main_divide_ratio(main_divide_ratio),
  .digital_probe_sel(digital_probe_sel), .analog_probe_sel(analog_probe_sel),
  .rx_data_out(rx_data_out), .load_pulse(load_pulse));

// ---- scb_ctrl_model.sv ----
`timescale 1ns/1ps

module scb_ctrl_model (
  // serial link toward the bank
  output logic sclk,
  output logic ld_strobe,
  output logic sdata
);
  // sole driver of the data line; the bank only listens
  initial
  begin
    sclk = 1'b0;
    ld_strobe = 1'b1;
    sdata = 1'b0;
  end

  // link clock runs inside frames and in noise(); data idles inverted so stale bits look wrong
  task automatic shift_word(input logic [15:0] w);
    ld_strobe = 1'b0;
    #37;
    for (int i = 15; i >= 0; i--)
    begin
      #20 sdata = w[i];
      #60 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #20 sdata = ~w[0];
  endtask

  task automatic load();
    #40 ld_strobe = 1'b1;
  endtask

  task automatic noise(input int n);
    for (int i = 0; i < n; i++)
    begin
      #80 sclk = 1'b1;
      sdata = ~sdata;
      #80 sclk = 1'b0;
    end
  endtask
endmodule // scb_ctrl_model

// ---- testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic clk, rstn, receive_on, sclk, ld_strobe, sdata, tx_power_pin_o, tx_power_pin_oe;
  logic tx_cw_mode, tx_lo_offset_en, rx_lo_offset_en, rx_loop_closed, pump_sink;
  logic rx_data_out, load_pulse;
  logic [3:0] ref_divide_ratio;
  logic [11:0] main_divide_ratio;
  logic [2:0] digital_probe_sel, analog_probe_sel;
  logic [15:0] pll_seen;
  logic [13:0] d;
  scb_pkg::scb_probe_src_t probe_src;
  int err_count, n_compared;

  scb_ctrl_model scb_ctrl_model_i (.sclk(sclk), .ld_strobe(ld_strobe), .sdata(sdata));
  scb_serial_config_bank scb_serial_config_bank_i (.clk(clk), .rstn(rstn), .sclk(sclk),
    .ld_strobe(ld_strobe), .sdata(sdata), .receive_on(receive_on), .probe_src(probe_src),
    .tx_power_pin_o(tx_power_pin_o), .tx_power_pin_oe(tx_power_pin_oe),
    .tx_cw_mode(tx_cw_mode), .tx_lo_offset_en(tx_lo_offset_en),
    .rx_lo_offset_en(rx_lo_offset_en), .rx_loop_closed(rx_loop_closed),
    .ref_divide_ratio(ref_divide_ratio), .pump_sink(pump_sink),
    .main_divide_ratio(main_divide_ratio), .digital_probe_sel(digital_probe_sel),
    .analog_probe_sel(analog_probe_sel), .rx_data_out(rx_data_out),
    .load_pulse(load_pulse));

  assign pll_seen = {7'h00, tx_cw_mode, tx_lo_offset_en, rx_lo_offset_en, rx_loop_closed,
    ref_divide_ratio, pump_sink};

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // strobe must stay high a while after the load, hence the trailing wait
  task automatic write_reg(input logic [1:0] a, input logic [13:0] v);
    int k;
    scb_ctrl_model_i.shift_word({v, a});
    scb_ctrl_model_i.load();
    k = 0;
    while (load_pulse !== 1'b1 && k < 12)
    begin
      tick(1);
      k++;
    end
    if (load_pulse !== 1'b1)
    begin
      err_count++;
      give_verdict();
    end
    tick(8);
  endtask

  function automatic logic [15:0] pll_exp(input logic [13:0] v);
    return {7'h00, v[4], v[3], ~v[3], v[2], v[1] ? scb_pkg::REF_DIV_HIGH :
      scb_pkg::REF_DIV_LOW, v[0]};
  endfunction

  function automatic logic mux_exp(input logic [2:0] s, input logic [3:0] p);
    case (s)
      3'h1: return p[2];
      3'h2: return p[1];
      3'h3: return p[0];
      default: return p[3];
    endcase
  endfunction

  task automatic check_defaults();
    check("pll outputs", pll_seen, pll_exp(14'h0000));
    check("divide ratio", {4'h0, main_divide_ratio}, 16'h0000);
    check("probe fields", {10'h000, digital_probe_sel, analog_probe_sel}, 16'h0000);
    check("power pin", {15'h0000, tx_power_pin_oe}, 16'h0000);
  endtask

  task automatic fall_rx();
    receive_on = 1'b0;
    tick(6);
    receive_on = 1'b1;
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    receive_on = 1'b1;
    probe_src = '0;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    #2 rstn = 1'b1;
    tick(2);
    check_defaults();
    $display("test reset defaults done");
    // pll loaded first, one bit at a time; the channel register is loaded later
    for (int b = 0; b < 6; b++)
    begin
      d = 14'h0001 << b;
      write_reg(scb_pkg::ADDR_PLL, d);
      check("pll outputs", pll_seen, pll_exp(d));
      check("power pin held", {15'h0000, tx_power_pin_oe}, 16'h0000);
    end
    fall_rx();
    check("power pin applied", {15'h0000, tx_power_pin_oe}, 16'h0001);
    write_reg(scb_pkg::ADDR_PLL, 14'h0000);
    check("power pin kept", {15'h0000, tx_power_pin_oe}, 16'h0001);
    fall_rx();
    check("power pin released", {15'h0000, tx_power_pin_oe}, 16'h0000);
    $display("test pll register done");
    scb_ctrl_model_i.shift_word(16'hffff);
    write_reg(scb_pkg::ADDR_CHAN, 14'h0a5c); // reserved bits zero
    check("divide ratio", {4'h0, main_divide_ratio}, 16'h0a5c);
    check("pll untouched", pll_seen, pll_exp(14'h0000));
    $display("test channel register done");
    for (int c = 0; c < 8; c++)
    begin
      write_reg(scb_pkg::ADDR_TEST, {8'h00, 3'(c), ~3'(c)});
      check("probe fields", {10'h000, digital_probe_sel, analog_probe_sel},
        {10'h000, 3'(c), ~3'(c)});
      for (int p = 0; p < 16; p++)
      begin
        probe_src = 4'(p);
        tick(2);
        check("rx data", {15'h0000, rx_data_out}, {15'h0000, mux_exp(3'(c), 4'(p))});
      end
    end
    $display("test probe routing done");
    scb_ctrl_model_i.shift_word({14'h3fff, scb_pkg::ADDR_NONE});
    scb_ctrl_model_i.load();
    tick(12);
    check("divide ratio", {4'h0, main_divide_ratio}, 16'h0a5c);
    check("probe fields", {10'h000, digital_probe_sel, analog_probe_sel}, 16'h0038);
    scb_ctrl_model_i.noise(16);
    tick(4);
    check("divide ratio", {4'h0, main_divide_ratio}, 16'h0a5c);
    write_reg(scb_pkg::ADDR_CHAN, 14'h0123);
    check("divide ratio", {4'h0, main_divide_ratio}, 16'h0123);
    $display("test ignored traffic done");
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    tick(2);
    check_defaults();
    $display("test second reset done");
    give_verdict();
  end
endmodule // testbench
